// File: pkg/srcl_pkg.sv
// Purpose: shared constants and types for the refresh command logic
// Assumes: six-bit command/address bus sampled on rising edges of clk_sys
// Notes:   cycle times are given in ns and converted to clk_sys cycles here
package srcl_pkg;

	// ----------------------------------------------------------------
	// command encoding, first edge
	// ----------------------------------------------------------------
	localparam int         CA_W           = 6;
	localparam logic [4:0] REF_CODE       = 5'h08;  // ca4..ca0 = 0,1,0,0,0
	localparam int         REF_ALL_BIT    = 5;      // high selects all-bank
	localparam int         BANK_LSB       = 0;      // bank bits on ca2..ca0, second edge
	localparam int         BANK_W         = 3;
	localparam int         NUM_BANKS      = 8;
	localparam int         ROW_W          = 16;

	// ----------------------------------------------------------------
	// reset values
	// ----------------------------------------------------------------
	localparam logic [2:0]  BANK_CNT_RST  = 3'h0;
	localparam logic [15:0] ROW_CNT_RST   = 16'h0000;

	// ----------------------------------------------------------------
	// timing
	// ----------------------------------------------------------------
	localparam int CLK_PERIOD_PS  = 25000;
	localparam int T_RFC_AB_NS    = 130;    // all_bank_refresh_cycle_time, plain default
	localparam int T_RFC_PB_NS    = 60;     // per_bank_refresh_cycle_time, plain default
	localparam int RFC_AB_CYC     = (T_RFC_AB_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
	localparam int RFC_PB_CYC     = (T_RFC_PB_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
	localparam int TMR_W          = 12;

	// decoder states
	typedef enum logic [1:0]
	{
		SRCL_IDLE   = 2'b01,
		SRCL_SECOND = 2'b10
	} srcl_dec_t;

endpackage : srcl_pkg

// File: pkg/srcl_tmr_if.sv
// Purpose: start/busy handshake between the refresh sequencer and a cycle timer
// Assumes: single clock domain
// Notes:   start is a one-cycle pulse with a load value
`timescale 1ns/1ps
interface srcl_tmr_if;
	logic                            start;
	logic [srcl_pkg::TMR_W-1:0]      load;
	logic                            busy;
	logic                            done;

	modport ctrl (output start, output load, input busy, input done);
	modport tmr  (input start, input load, output busy, output done);
endinterface : srcl_tmr_if

// File: rtl/srcl_cycle_timer.sv
// Purpose: down-counter that marks a refresh cycle as busy for a loaded number of cycles
// Assumes: load value at least one
// Notes:   done pulses in the cycle the count reaches zero
`timescale 1ns/1ps
module srcl_cycle_timer
(
	// clock and reset
	input  wire logic clk_sys,
	input  wire logic sys_rst,
	// control
	srcl_tmr_if.tmr   tmr
);

	logic [srcl_pkg::TMR_W-1:0] cnt_r;
	logic [srcl_pkg::TMR_W-1:0] cnt_nxt;
	logic                       done_nxt;
	logic                       done_r;

	// ----------------------------------------------------------------
	// next count
	// ----------------------------------------------------------------
	always_comb
	begin
		cnt_nxt  = cnt_r;
		done_nxt = 1'b0;
		if (tmr.start)
			cnt_nxt = tmr.load;
		else if (cnt_r != '0)
		begin
			cnt_nxt  = cnt_r - 1'b1;
			done_nxt = (cnt_r == {{(srcl_pkg::TMR_W-1){1'b0}}, 1'b1});
		end
	end

	// register
	always_ff @(posedge clk_sys)
	begin
		if (sys_rst)
		begin
			cnt_r  <= '0;
			done_r <= 1'b0;
		end
		else
		begin
			cnt_r  <= cnt_nxt;
			done_r <= done_nxt;
		end
	end

	assign tmr.busy = (cnt_r != '0);
	assign tmr.done = done_r;

endmodule : srcl_cycle_timer

// File: rtl/srcl_refresh.sv
// Purpose: refresh command decode, per-bank bank counter, row counter and bank-busy tracking
// Assumes: ca, cs and the self-refresh exit strobe come from pins and are synchronised here
// Notes:   the far-end controller keeps the separation times; this block only reports them
`timescale 1ns/1ps

// Functional notes
// [RULE1] refresh recognised with cs high and ca4..ca0 = 0,1,0,0,0 on first edge
// [RULE2] ca5 low on first edge means per-bank refresh, high means all-bank
// [RULE3] per-bank target bank taken from ca2..ca0 on the second edge
// [RULE4] controller refreshes each of eight banks once per set, any order
// [RULE5] bank counter cleared by reset, self-refresh exit and all-bank refresh; an exit in the same cycle as a per-bank step is ignored
// [RULE6] a set of eight starts at the first per-bank refresh after synchronisation
// [RULE7] self refresh or all-bank refresh allowed with an incomplete set
// [RULE8] all-bank refresh clears bank counter and refreshes all banks at current row
// [RULE9] bank counter wraps 7 to 0; row advances after a set or all-bank refresh
// [RULE10] controller refreshes only idle banks and tracks the target bank itself
// [RULE11] controller keeps cycle times and delays before a per-bank refresh
// [RULE12] only the target bank is inaccessible during the per-bank cycle
// [RULE13] the refreshed bank is idle when the per-bank cycle completes
// [RULE14] controller waits per-bank cycle time and activate delay after per-bank refresh
// [RULE15] controller idles all banks before an all-bank refresh
// [RULE16] controller keeps cycle times and precharge period before an all-bank refresh
// [RULE17] all banks idle after all-bank refresh; controller waits its cycle time
// [RULE18] no all-bank refresh after activate; per-bank only to idle bank
// [RULE19] controller separates activates to different banks by the activate delay
module srcl_refresh
#(
	parameter int RFC_AB = srcl_pkg::RFC_AB_CYC,
	parameter int RFC_PB = srcl_pkg::RFC_PB_CYC
)
(
	// clock and reset
	input  wire logic                            clk_sys,
	input  wire logic                            sys_rst,
	// command pins
	input  wire logic                            cs_pin,
	input  wire logic [srcl_pkg::CA_W-1:0]       ca_pin,
	input  wire logic                            self_refresh_exit,
	// refresh activity towards the array
	output logic                                 refresh_pulse,
	output logic                                 refresh_all,
	output logic [srcl_pkg::BANK_W-1:0]          refresh_bank,
	output logic [srcl_pkg::ROW_W-1:0]           refresh_row,
	// state
	output logic [srcl_pkg::NUM_BANKS-1:0]       bank_busy,
	output logic [srcl_pkg::BANK_W-1:0]          bank_count,
	output logic [srcl_pkg::ROW_W-1:0]           row_count
);

	// ----------------------------------------------------------------
	// input synchronisers
	// ----------------------------------------------------------------
	logic [srcl_pkg::CA_W+1:0] sync1_r;
	logic [srcl_pkg::CA_W+1:0] sync2_r;
	logic                      exit_q_r;
	logic                      cs_s;
	logic [srcl_pkg::CA_W-1:0] ca_s;
	logic                      exit_s;
	logic                      exit_rise;

	// two stages; only the second stage feeds logic
	always_ff @(posedge clk_sys)
	begin
		if (sys_rst)
		begin
			sync1_r <= '0;
			sync2_r <= '0;
			exit_q_r <= 1'b0;
		end
		else
		begin
			sync1_r <= {self_refresh_exit, cs_pin, ca_pin};
			sync2_r <= sync1_r;
			exit_q_r <= sync2_r[srcl_pkg::CA_W+1];
		end
	end

	assign ca_s      = sync2_r[srcl_pkg::CA_W-1:0];
	assign cs_s      = sync2_r[srcl_pkg::CA_W];
	assign exit_s    = sync2_r[srcl_pkg::CA_W+1];
	assign exit_rise = exit_s & ~exit_q_r;        // one sync event per exit

	// ----------------------------------------------------------------
	// decode helper
	// ----------------------------------------------------------------
	function automatic logic is_refresh(input logic cs, input logic [srcl_pkg::CA_W-1:0] ca);
		is_refresh = cs && (ca[4:0] == srcl_pkg::REF_CODE); // RULE1
	endfunction : is_refresh

	// ----------------------------------------------------------------
	// command decode and counters
	// ----------------------------------------------------------------
	srcl_pkg::srcl_dec_t                 st_r, st_nxt;
	logic [srcl_pkg::BANK_W-1:0]         bcnt_r, bcnt_nxt;
	logic [srcl_pkg::ROW_W-1:0]          row_r, row_nxt;
	logic                                pulse_r, pulse_nxt;
	logic                                all_r, all_nxt;
	logic [srcl_pkg::BANK_W-1:0]         bank_r, bank_nxt;
	logic [srcl_pkg::ROW_W-1:0]          rrow_r, rrow_nxt;
	logic [srcl_pkg::NUM_BANKS-1:0]      busy_r, busy_nxt;
	logic                                pb_go;
	logic                                ab_go;
	logic [srcl_pkg::BANK_W-1:0]         pb_bank;

	srcl_tmr_if tif_ab ();
	srcl_tmr_if tif_pb [srcl_pkg::NUM_BANKS] ();

	// a single decoder; a per-bank refresh on the first edge arms the second-edge capture
	always_comb
	begin
		st_nxt    = st_r;
		bcnt_nxt  = bcnt_r;
		row_nxt   = row_r;
		pulse_nxt = 1'b0;
		all_nxt   = all_r;
		bank_nxt  = bank_r;
		rrow_nxt  = rrow_r;
		pb_go     = 1'b0;
		ab_go     = 1'b0;
		pb_bank   = ca_s[srcl_pkg::BANK_LSB +: srcl_pkg::BANK_W]; // RULE3
		case (st_r)
			srcl_pkg::SRCL_IDLE:
			begin
				if (is_refresh(cs_s, ca_s))
				begin
					if (ca_s[srcl_pkg::REF_ALL_BIT]) // RULE2
					begin
						// all-bank refresh at current row, then row advances
						ab_go     = 1'b1;
						pulse_nxt = 1'b1;
						all_nxt   = 1'b1;
						rrow_nxt  = row_r;          // RULE8
						row_nxt   = row_r + 1'b1;   // RULE9
						bcnt_nxt  = srcl_pkg::BANK_CNT_RST; // RULE5 RULE7
					end
					else
						st_nxt = srcl_pkg::SRCL_SECOND;
				end
			end
			srcl_pkg::SRCL_SECOND:
			begin
				// per-bank: bank taken now, counter advances and wraps
				st_nxt    = srcl_pkg::SRCL_IDLE;
				pb_go     = 1'b1;
				pulse_nxt = 1'b1;
				all_nxt   = 1'b0;
				bank_nxt  = pb_bank;
				rrow_nxt  = row_r;
				bcnt_nxt  = bcnt_r + 1'b1;       // RULE9 RULE6
				if (bcnt_r == 3'h7)
					row_nxt = row_r + 1'b1;      // RULE9
			end
			default:
				st_nxt = srcl_pkg::SRCL_IDLE;
		endcase
		// self-refresh exit resynchronises; ignored if it coincides with a counter step
		if (exit_rise && !pb_go && !ab_go)
			bcnt_nxt = srcl_pkg::BANK_CNT_RST;   // RULE5
	end

	// ----------------------------------------------------------------
	// cycle timers: one all-bank, one per bank so others stay usable
	// ----------------------------------------------------------------
	assign tif_ab.start = ab_go;
	assign tif_ab.load  = srcl_pkg::TMR_W'(RFC_AB);

	srcl_cycle_timer u_tmr_ab
	(
		.clk_sys (clk_sys),
		.sys_rst (sys_rst),
		.tmr     (tif_ab)
	);

	genvar gi;
	generate
		for (gi = 0; gi < srcl_pkg::NUM_BANKS; gi++)
		begin : g_bank
			assign tif_pb[gi].start = pb_go && (pb_bank == srcl_pkg::BANK_W'(gi)); // RULE12
			assign tif_pb[gi].load  = srcl_pkg::TMR_W'(RFC_PB);

			srcl_cycle_timer u_tmr_pb
			(
				.clk_sys (clk_sys),
				.sys_rst (sys_rst),
				.tmr     (tif_pb[gi])
			);

			// busy only while this bank or an all-bank cycle runs; idle one cycle after both timers expire
			assign busy_nxt[gi] = tif_pb[gi].start || ab_go || tif_pb[gi].busy || tif_ab.busy; // RULE13 RULE17
		end
	endgenerate

	// register
	always_ff @(posedge clk_sys)
	begin
		if (sys_rst)
		begin
			st_r    <= srcl_pkg::SRCL_IDLE;
			bcnt_r  <= srcl_pkg::BANK_CNT_RST;   // RULE5
			row_r   <= srcl_pkg::ROW_CNT_RST;
			pulse_r <= 1'b0;
			all_r   <= 1'b0;
			bank_r  <= '0;
			rrow_r  <= srcl_pkg::ROW_CNT_RST;
			busy_r  <= '0;
		end
		else
		begin
			st_r    <= st_nxt;
			bcnt_r  <= bcnt_nxt;
			row_r   <= row_nxt;
			pulse_r <= pulse_nxt;
			all_r   <= all_nxt;
			bank_r  <= bank_nxt;
			rrow_r  <= rrow_nxt;
			busy_r  <= busy_nxt;
		end
	end

	assign refresh_pulse = pulse_r;
	assign refresh_all   = all_r;
	assign refresh_bank  = bank_r;
	assign refresh_row   = rrow_r;
	assign bank_busy     = busy_r;
	assign bank_count    = bcnt_r;
	assign row_count     = row_r;

endmodule : srcl_refresh

// File: verification/srcl_refresh_assertions.sv
// Purpose: temporal checks on the refresh command logic ports
// Assumes: default cycle times, pins pass two sync flops
// Notes:   decode state is rebuilt here from the pin stream
`timescale 1ns/1ps
module srcl_chk
#(
	parameter int RFC_AB = srcl_pkg::RFC_AB_CYC,
	parameter int RFC_PB = srcl_pkg::RFC_PB_CYC
)
(
	// clock and reset
	input wire logic                          clk_sys,
	input wire logic                          sys_rst,
	// command pins
	input wire logic                          cs_pin,
	input wire logic [srcl_pkg::CA_W-1:0]     ca_pin,
	input wire logic                          self_refresh_exit,
	// refresh activity and state
	input wire logic                          refresh_pulse,
	input wire logic                          refresh_all,
	input wire logic [srcl_pkg::BANK_W-1:0]   refresh_bank,
	input wire logic [srcl_pkg::ROW_W-1:0]    refresh_row,
	input wire logic [srcl_pkg::NUM_BANKS-1:0] bank_busy,
	input wire logic [srcl_pkg::BANK_W-1:0]   bank_count,
	input wire logic [srcl_pkg::ROW_W-1:0]    row_count
);
	default clocking @(posedge clk_sys); endclocking
	default disable iff (sys_rst);
	logic sec_r, sec_nxt, ab_cmd, pb_cmd;
	// a bank cycle is never an opcode, so track the second edge ourselves
	assign ab_cmd = cs_pin && !sec_r && ca_pin == 6'h28;
	assign pb_cmd = cs_pin && !sec_r && ca_pin == 6'h08;
	always_comb sec_nxt = pb_cmd;
	always_ff @(posedge clk_sys) sec_r <= sys_rst ? 1'b0 : sec_nxt;
	// ----------------------------------------------------------------
	// properties
	// ----------------------------------------------------------------
	property p_ab; ab_cmd |-> ##3 refresh_pulse && refresh_all && bank_count == 3'h0 && bank_busy == 8'hFF; endproperty
	a_ab: assert property (p_ab) else $error("all-bank refresh not started");
	property p_pb; pb_cmd |-> ##4 refresh_pulse && !refresh_all && refresh_bank == $past(ca_pin[2:0], 3); endproperty
	a_pb: assert property (p_pb) else $error("per-bank refresh wrong");
	property p_src; refresh_pulse |-> $past(ab_cmd, 3) || $past(pb_cmd, 4); endproperty
	a_src: assert property (p_src) else $error("refresh without command");
	property p_cnt; refresh_pulse && !refresh_all |-> bank_count == 3'($past(bank_count) + 3'h1); endproperty
	a_cnt: assert property (p_cnt) else $error("bank counter step wrong");
	property p_row; refresh_pulse && !refresh_all |-> refresh_row == $past(row_count)
		&& row_count == 16'($past(row_count) + (($past(bank_count) == 3'h7) ? 16'h1 : 16'h0)); endproperty
	a_row: assert property (p_row) else $error("row step after set wrong");
	property p_abrow; refresh_pulse && refresh_all |-> refresh_row == $past(row_count)
		&& row_count == 16'($past(row_count) + 16'h1); endproperty
	a_abrow: assert property (p_abrow) else $error("all-bank row wrong");
	property p_exit; $rose(self_refresh_exit) |-> ##[3:4] bank_count == 3'h0; endproperty
	a_exit: assert property (p_exit) else $error("exit did not clear counter");
	property p_busy; refresh_pulse && !refresh_all && $past(bank_busy) == 8'h00 |-> bank_busy == 8'h01 << refresh_bank;
	endproperty
	a_busy: assert property (p_busy) else $error("other banks blocked");
	property p_idle; refresh_pulse ##1 !refresh_pulse [*8] |-> bank_busy == 8'h00; endproperty
	a_idle: assert property (p_idle) else $error("bank left busy");
	c_ab: cover property (ab_cmd ##3 refresh_pulse);
	c_wrap: cover property (refresh_pulse && !refresh_all && bank_count == 3'h0);
	c_exit: cover property ($rose(self_refresh_exit));
endmodule : srcl_chk
bind srcl_refresh srcl_chk #(.RFC_AB(RFC_AB), .RFC_PB(RFC_PB)) u_chk (.clk_sys(clk_sys), .sys_rst(sys_rst),
	.cs_pin(cs_pin), .ca_pin(ca_pin), .self_refresh_exit(self_refresh_exit), .refresh_pulse(refresh_pulse),
	.refresh_all(refresh_all), .refresh_bank(refresh_bank), .refresh_row(refresh_row), .bank_busy(bank_busy),
	.bank_count(bank_count), .row_count(row_count));

// File: verification/srcl_host_model.sv
// Purpose: memory controller model driving the command pins
// Assumes: never activates a bank, so every bank is idle when refreshed
// Notes:   idle address lines toggle so stale values never look valid
`timescale 1ns/1ps
module srcl_host_model
#(
	parameter int GAP = 12
)
(
	// clock
	input wire logic                      clk_sys,
	// command pins
	output logic                          cs_pin,
	output logic [srcl_pkg::CA_W-1:0]     ca_pin,
	output logic                          self_refresh_exit
);
	logic active = 1'b0;
	initial cs_pin = 1'b0;
	initial ca_pin = 6'h15;
	initial self_refresh_exit = 1'b0;
	// deselected bus changes every cycle
	always @(posedge clk_sys) if (!active) ca_pin <= ~ca_pin;
	// opcode edge, then bank edge for per-bank
	task automatic send(input logic all, input logic [2:0] bank);
		active = 1'b1;
		@(posedge clk_sys);
		cs_pin <= 1'b1;
		ca_pin <= {all, 5'h08};
		if (!all)
		begin
			@(posedge clk_sys);
			cs_pin <= 1'b0;
			ca_pin <= {3'($urandom), bank};
		end
		@(posedge clk_sys);
		cs_pin <= 1'b0;
		@(negedge clk_sys);
		active = 1'b0;
	endtask : send
	task automatic exit_pulse();
		@(posedge clk_sys);
		self_refresh_exit <= 1'b1;
		repeat (3) @(posedge clk_sys);
		self_refresh_exit <= 1'b0;
	endtask : exit_pulse
	// spacing covers the longest refresh cycle time
	task automatic settle();
		repeat (GAP) @(posedge clk_sys);
	endtask : settle
endmodule : srcl_host_model

// File: verification/tb_top.sv
// Purpose: self-checking bench for the refresh command logic
// Assumes: default cycle times of the package
// Notes:   expected counters are kept by the bench itself
`timescale 1ns/1ps
`define CHK(a, e) begin check_count++; if ((a) !== (e)) begin fail_count++; $display("unexpected at %0t: got %h expected %h", $time, a, e); end end
module tb_top;
	logic        clk_sys, sys_rst, cs_pin, self_refresh_exit, refresh_pulse, refresh_all;
	logic [5:0]  ca_pin;
	logic [2:0]  refresh_bank, bank_count, cnt_e;
	logic [15:0] refresh_row, row_count, row_e;
	logic [7:0]  bank_busy, used;
	int          fail_count = 0;
	int          check_count = 0;
	srcl_refresh DUT (.clk_sys(clk_sys), .sys_rst(sys_rst), .cs_pin(cs_pin), .ca_pin(ca_pin),
		.self_refresh_exit(self_refresh_exit), .refresh_pulse(refresh_pulse), .refresh_all(refresh_all),
		.refresh_bank(refresh_bank), .refresh_row(refresh_row), .bank_busy(bank_busy), .bank_count(bank_count),
		.row_count(row_count));
	srcl_host_model host (.clk_sys(clk_sys), .cs_pin(cs_pin), .ca_pin(ca_pin), .self_refresh_exit(self_refresh_exit));
	initial
	begin
		clk_sys = 1'b0;
		forever #12.5 clk_sys = ~clk_sys;
	end
	task automatic stop_test();
		$display("checks %0d mismatches %0d", check_count, fail_count);
		if (fail_count == 0 && check_count > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask : stop_test
	function automatic logic [15:0] row_after(input logic [2:0] c, input logic [15:0] r);
		return (c == 3'h7) ? 16'(r + 16'h1) : r;
	endfunction : row_after
	// random bank not yet refreshed in this set
	function automatic logic [2:0] free_bank();
		logic [2:0] b;
		b = 3'($urandom);
		while (used[b]) b++;
		return b;
	endfunction : free_bank
	task automatic do_ref(input logic all, input logic [2:0] bank);
		host.send(all, bank);
		repeat (16)
		begin
			@(posedge clk_sys);
			#1;
			if (refresh_pulse === 1'b1) break;
		end
		if (refresh_pulse !== 1'b1)
		begin
			fail_count++;
			stop_test();
		end
		`CHK(refresh_all, all)
		`CHK(refresh_row, row_e)
		if (all)
		begin
			`CHK(bank_busy, 8'hFF)
			row_e = 16'(row_e + 16'h1);
			cnt_e = 3'h0;
			used = 8'h00;
		end
		else
		begin
			`CHK(refresh_bank, bank)
			`CHK(bank_busy, 8'h01 << bank)
			row_e = row_after(cnt_e, row_e);
			cnt_e++;
			used = (cnt_e == 3'h0) ? 8'h00 : used | (8'h01 << bank);
		end
		`CHK(bank_count, cnt_e)
		`CHK(row_count, row_e)
		host.settle();
		#1;
		`CHK(bank_busy, 8'h00)
	endtask : do_ref
	initial
	begin
		sys_rst = 1'b1;
		cnt_e = 3'h0;
		row_e = 16'h0000;
		used = 8'h00;
		void'($urandom(32'hA89520A5));
		repeat (6) @(posedge clk_sys);
		sys_rst <= 1'b0;
		@(posedge clk_sys);
		#1;
		`CHK(bank_count, 3'h0)
		`CHK(row_count, 16'h0000)
		`CHK(bank_busy, 8'h00)
		$display("test reset done");
		for (int i = 0; i < 8; i++) do_ref(1'b0, 3'(i));
		do_ref(1'b0, 3'h5);
		do_ref(1'b0, 3'h2);
		do_ref(1'b1, 3'h0);
		$display("test set and all-bank done");
		repeat (48)
		begin
			case ($urandom_range(0, 5))
				0: do_ref(1'b1, 3'h0);
				1:
				begin
					host.exit_pulse();
					repeat (6) @(posedge clk_sys);
					#1;
					`CHK(bank_count, 3'h0)
					cnt_e = 3'h0;
					used = 8'h00;
				end
				default: do_ref(1'b0, free_bank());
			endcase
		end
		$display("test random mix done");
		// reset in mid-run must bring both counters back to zero
		sys_rst <= 1'b1;
		repeat (2) @(posedge clk_sys);
		sys_rst <= 1'b0;
		@(posedge clk_sys);
		#1;
		`CHK(bank_count, 3'h0)
		`CHK(row_count, 16'h0000)
		cnt_e = 3'h0;
		row_e = 16'h0000;
		used = 8'h00;
		do_ref(1'b0, free_bank());
		$display("test mid-run reset done");
		stop_test();
	end
endmodule : tb_top
